/* File: hdl/dav_delta_outputs.sv */
// delta angle (x,y,z) and x delta velocity integration and output words
//
// How it works
// - angle high word is signed twos complement; zero rotation reads 0x0000.
// - low 16 bits of each 32-bit angle sit in a paired low word.
// - high word alone counts full scale over 2^15, saturating 7fff/8000.
// - 32-bit pair counts full scale over 2^31, saturating at the limits.
// - velocity is sum of sample plus predecessor over D, times 1/(2fs).
// - integrate undecimated samples over decimation setting plus one.
// - with the internal sample clock the integration rate is nominally 2000.
// - velocity high word spans +-400 m/sec, zero at 0x0000.
// - velocity low word holds extra bits forming a 32-bit value.
// - y and z axes use the same pair layout and scaling.
// - each result covers only the last update interval, not a total.
// - angles use the same trapezoid sum and length as velocity.
// - angle full scale is 360, 720 or 2160 degrees by range variant.
`default_nettype none
module dav_delta_outputs #(
    parameter int SAMP_W = 24,
    parameter int DEC_W  = 16
) (
    input  wire logic                          sys_clk_i,
    input  wire logic                          rst_i,
    input  wire logic                          sample_strobe_i,
    input  wire logic signed [SAMP_W-1:0]      gyro_x_i,
    input  wire logic signed [SAMP_W-1:0]      gyro_y_i,
    input  wire logic signed [SAMP_W-1:0]      gyro_z_i,
    input  wire logic signed [SAMP_W-1:0]      accel_x_i,
    input  wire logic [DEC_W-1:0]              decimation_setting_i,
    input  wire logic [1:0]                    range_sel_i,
    input  wire logic                          reg_rd_i,
    input  wire logic [dav_pkg::ADDR_W-1:0]    reg_addr_i,
    output logic [dav_pkg::HALF_W-1:0]         reg_rdata_o,
    output logic                               reg_rvalid_o,
    output logic                               sample_ready_pin_o
);
    // a sum of up to 2^DEC_W sample pairs never overflows
    localparam int ACC_W = SAMP_W + 1 + DEC_W;
    localparam int NCH   = dav_pkg::NUM_CH;

    logic signed [SAMP_W-1:0]        samp_w   [NCH];
    logic signed [SAMP_W-1:0]        prev_r   [NCH];
    logic signed [ACC_W-1:0]         pair_w   [NCH];
    logic signed [ACC_W-1:0]         acc_nxt  [NCH];
    logic signed [ACC_W-1:0]         acc_r    [NCH];
    logic signed [ACC_W-1:0]         hold_r   [NCH];
    logic [dav_pkg::GAIN_W-1:0]      gain_w   [NCH];
    logic signed [dav_pkg::RES_W-1:0] res_w   [NCH];

    logic [DEC_W-1:0]                cnt_r;
    logic [DEC_W-1:0]                cnt_nxt;
    logic [DEC_W-1:0]                dec_len_r;
    logic [1:0]                      range_r;
    logic                            last_w;
    logic [dav_pkg::GAIN_W-1:0]      ang_gain_w;
    dav_pkg::dav_phase_t             phase_r;
    dav_pkg::dav_phase_t             phase_nxt;

    // angle input unit is the 2160 degree scale per sample period;
    // narrower variants give more counts for the same rotation
    function automatic logic [dav_pkg::GAIN_W-1:0] gain_for(
        input logic [1:0] sel
    );
        logic [dav_pkg::GAIN_W-1:0] g;
        g = dav_pkg::GAIN_2160;
        unique case (sel)
            dav_pkg::RANGE_360:  g = dav_pkg::GAIN_360;
            dav_pkg::RANGE_720:  g = dav_pkg::GAIN_720;
            default:             g = dav_pkg::GAIN_2160;
        endcase
        return g;
    endfunction

    assign samp_w[0] = gyro_x_i;
    assign samp_w[1] = gyro_y_i;
    assign samp_w[2] = gyro_z_i;
    assign samp_w[3] = accel_x_i;

    assign ang_gain_w = gain_for(range_r);
    assign gain_w[0]  = ang_gain_w;
    assign gain_w[1]  = ang_gain_w;
    assign gain_w[2]  = ang_gain_w;
    assign gain_w[3]  = dav_pkg::GAIN_VEL;

    // D = setting + 1 samples: count runs 0 .. setting
    assign last_w  = sample_strobe_i && (cnt_r == dec_len_r);
    assign cnt_nxt = last_w ? '0 : cnt_r + 1'b1;

    // trapezoid: each sample paired with its predecessor
    genvar g;
    generate
        for (g = 0; g < NCH; g++) begin : g_ch
            assign pair_w[g]  = ACC_W'(samp_w[g]) + ACC_W'(prev_r[g]);
            assign acc_nxt[g] = acc_r[g] + pair_w[g];

            always_ff @(posedge sys_clk_i or posedge rst_i) begin
                if (rst_i) begin
                    prev_r[g] <= '0;
                    acc_r[g]  <= '0;
                    hold_r[g] <= '0;
                // one integration step per internal sample
                end else if (sample_strobe_i) begin
                    prev_r[g] <= samp_w[g];
                    if (last_w) begin
                        acc_r[g]  <= '0;
                        hold_r[g] <= acc_nxt[g];
                    end else begin
                        acc_r[g]  <= acc_nxt[g];
                    end
                end
            end

            // 1/(2 fs): fs is folded into the sample unit, the 2 here
            dav_sat_scale #(
                .IN_W   (ACC_W)
            ) u_scale (
                .sum_i  (hold_r[g]),
                .gain_i (gain_w[g]),
                .res_o  (res_w[g])
            );
        end
    endgenerate

    // setting takes effect from the next interval onward, range from the
    // result of the interval just ending, so one output never mixes two lengths or two scales
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_r     <= '0;
            dec_len_r <= DEC_W'(dav_pkg::DEC_RESET);
            range_r   <= dav_pkg::RANGE_2160;
        end else if (sample_strobe_i) begin
            cnt_r <= cnt_nxt;
            if (last_w) begin
                dec_len_r <= decimation_setting_i;
                range_r   <= range_sel_i;
            end
        end
    end

    assign phase_nxt = last_w ? dav_pkg::PH_LOAD : dav_pkg::PH_IDLE;

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            phase_r            <= dav_pkg::PH_IDLE;
            sample_ready_pin_o <= 1'b0;
        end else begin
            phase_r            <= phase_nxt;
            // ready rises on the edge that makes the new words readable
            sample_ready_pin_o <= (phase_r == dav_pkg::PH_LOAD);
        end
    end

    dav_regfile u_regs (
        .sys_clk_i (sys_clk_i),
        .rst_i     (rst_i),
        .load_i    (phase_r == dav_pkg::PH_LOAD),
        .word0_i   (res_w[0]),
        .word1_i   (res_w[1]),
        .word2_i   (res_w[2]),
        .word3_i   (res_w[3]),
        .rd_i      (reg_rd_i),
        .addr_i    (reg_addr_i),
        .rdata_o   (reg_rdata_o),
        .rvalid_o  (reg_rvalid_o)
    );
endmodule
`default_nettype wire

/* File: hdl/dav_pkg.sv */
// constants shared by the delta angle / delta velocity output block
`default_nettype none
package dav_pkg;
    localparam int NUM_CH    = 4;
    localparam int NUM_WORDS = 8;
    localparam int RES_W     = 32;
    localparam int HALF_W    = 16;
    localparam int ADDR_W    = 7;
    localparam int GAIN_W    = 3;

    // byte addresses of the 16-bit result words
    localparam logic [6:0] OFS_X_ANG_LO = 7'h24;
    localparam logic [6:0] OFS_X_ANG_HI = 7'h26;
    localparam logic [6:0] OFS_Y_ANG_LO = 7'h28;
    localparam logic [6:0] OFS_Y_ANG_HI = 7'h2a;
    localparam logic [6:0] OFS_Z_ANG_LO = 7'h2c;
    localparam logic [6:0] OFS_Z_ANG_HI = 7'h2e;
    localparam logic [6:0] OFS_X_VEL_LO = 7'h30;
    localparam logic [6:0] OFS_X_VEL_HI = 7'h32;
    localparam logic [6:0] OFS_LAST     = 7'h33;

    localparam logic [15:0] WORD_RESET = 16'h0000;
    localparam logic [15:0] WORD_UNMAP = 16'h0000;
    localparam logic [15:0] DEC_RESET  = 16'h0000;

    // saturation limits of the 32-bit result
    localparam logic signed [31:0] RES_MAX = 32'sh7fffffff;
    localparam logic signed [31:0] RES_MIN = 32'sh80000000;

    // angle input unit is the widest range; narrower ranges scale up
    localparam logic [2:0] GAIN_360  = 3'h6;
    localparam logic [2:0] GAIN_720  = 3'h3;
    localparam logic [2:0] GAIN_2160 = 3'h1;
    localparam logic [2:0] GAIN_VEL  = 3'h1;

    typedef enum logic [1:0] {
        RANGE_360  = 2'b00,
        RANGE_720  = 2'b01,
        RANGE_2160 = 2'b10
    } dav_range_t;

    typedef enum logic {
        PH_IDLE = 1'b0,
        PH_LOAD = 1'b1
    } dav_phase_t;
endpackage
`default_nettype wire

/* File: hdl/dav_regfile.sv */
// eight read-only 16-bit result words, loaded as one set
`default_nettype none
module dav_regfile (
    input  wire logic                          sys_clk_i,
    input  wire logic                          rst_i,
    input  wire logic                          load_i,
    input  wire logic [dav_pkg::RES_W-1:0]     word0_i,
    input  wire logic [dav_pkg::RES_W-1:0]     word1_i,
    input  wire logic [dav_pkg::RES_W-1:0]     word2_i,
    input  wire logic [dav_pkg::RES_W-1:0]     word3_i,
    input  wire logic                          rd_i,
    input  wire logic [dav_pkg::ADDR_W-1:0]    addr_i,
    output logic [dav_pkg::HALF_W-1:0]         rdata_o,
    output logic                               rvalid_o
);
    logic [dav_pkg::HALF_W-1:0] mem_r [dav_pkg::NUM_WORDS];
    logic [dav_pkg::RES_W-1:0]  word_w [dav_pkg::NUM_CH];
    logic [dav_pkg::ADDR_W-1:0] rel_w;
    logic [2:0]                 idx_w;
    logic                       hit_w;

    assign word_w[0] = word0_i;
    assign word_w[1] = word1_i;
    assign word_w[2] = word2_i;
    assign word_w[3] = word3_i;

    // both byte addresses of one 16-bit word select that same word
    assign rel_w = addr_i - dav_pkg::OFS_X_ANG_LO;
    assign idx_w = rel_w[3:1];
    assign hit_w = (addr_i >= dav_pkg::OFS_X_ANG_LO) &&
                   (addr_i <= dav_pkg::OFS_LAST);

    // every low and high word is written on the same edge
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            for (int i = 0; i < dav_pkg::NUM_WORDS; i++) begin
                mem_r[i] <= dav_pkg::WORD_RESET;
            end
        end else if (load_i) begin
            for (int j = 0; j < dav_pkg::NUM_CH; j++) begin
                mem_r[2*j]   <= word_w[j][15:0];
                mem_r[2*j+1] <= word_w[j][31:16];
            end
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_o  <= dav_pkg::WORD_UNMAP;
            rvalid_o <= 1'b0;
        end else begin
            rvalid_o <= rd_i;
            if (rd_i) begin
                rdata_o <= hit_w ? mem_r[idx_w] : dav_pkg::WORD_UNMAP;
            end
        end
    end
endmodule
`default_nettype wire

/* File: hdl/dav_sat_scale.sv */
// gain, halving and saturation of one integrated sum to 32 bits
`default_nettype none
module dav_sat_scale #(
    parameter int IN_W = 41
) (
    input  wire logic signed [IN_W-1:0]            sum_i,
    input  wire logic [dav_pkg::GAIN_W-1:0]        gain_i,
    output logic signed [dav_pkg::RES_W-1:0]       res_o
);
    localparam int PW = IN_W + dav_pkg::GAIN_W + 1;

    logic signed [PW-1:0] prod_w;
    logic signed [PW-1:0] half_w;
    logic signed [PW-1:0] max_w;
    logic signed [PW-1:0] min_w;
    logic                 ovf_pos_w;
    logic                 ovf_neg_w;

    assign prod_w = PW'(sum_i) * PW'($signed({1'b0, gain_i}));
    // the 1/2 of the trapezoid sum is applied here, after the gain
    assign half_w = prod_w >>> 1;
    assign max_w  = PW'(dav_pkg::RES_MAX);
    assign min_w  = PW'(dav_pkg::RES_MIN);
    assign ovf_pos_w = half_w > max_w;
    assign ovf_neg_w = half_w < min_w;
    assign res_o = ovf_pos_w ? dav_pkg::RES_MAX :
                   ovf_neg_w ? dav_pkg::RES_MIN :
                   half_w[dav_pkg::RES_W-1:0];
endmodule
`default_nettype wire

/* File: verification/dav_delta_outputs_bench.sv */
// self-checking bench for the delta output block
`default_nettype none
module dav_delta_outputs_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic               sys_clk_i = 1'b0;
    logic               rst_i = 1'b0;
    logic               strb = 1'b0;
    logic signed [23:0] smp [4] = '{default: 24'sh0};
    logic [15:0]        dec = 16'h0000;
    logic [1:0]         rng = 2'b00;
    logic               rd, rvalid, rdy;
    logic [6:0]         addr;
    logic [15:0]        rdata;
    integer             seed = 32'h98f74a6b;
    int                 err_total = 0, n_checks = 0, nrdy = 0;
    longint             acc [4] = '{default: 0}, prv [4] = '{default: 0};
    logic [15:0]        expq [$];
    always #50 sys_clk_i = ~sys_clk_i;
    dav_host_model host (.sys_clk_i(sys_clk_i), .reg_rd_o(rd),
        .reg_addr_o(addr));
    dav_delta_outputs DUT (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
        .sample_strobe_i(strb), .gyro_x_i(smp[0]), .gyro_y_i(smp[1]),
        .gyro_z_i(smp[2]), .accel_x_i(smp[3]), .decimation_setting_i(dec),
        .range_sel_i(rng), .reg_rd_i(rd), .reg_addr_i(addr),
        .reg_rdata_o(rdata), .reg_rvalid_o(rvalid), .sample_ready_pin_o(rdy));
    task automatic test_done;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // sampled mid-cycle so registered outputs have settled
    always @(negedge sys_clk_i) begin
        if (rdy === 1'b1) nrdy++;
        if (rvalid === 1'b1) begin
            n_checks++;
            if (expq.size() == 0 || expq[0] !== rdata) begin
                $display("MISMATCH t=%0t exp=%h got=%h", $time,
                    expq.size() ? expq[0] : 16'hxxxx, rdata);
                err_total++;
            end
            if (expq.size()) void'(expq.pop_front());
        end
    end
    function automatic logic [15:0] expw(input logic [6:0] a);
        int         c;
        longint     v;
        logic [2:0] g;
        if (a < 7'h24 || a > 7'h33) return 16'h0000;
        c = (int'(a) - 36) / 4;
        g = (c == 3) ? dav_pkg::GAIN_VEL : rng[1] ? dav_pkg::GAIN_2160 :
            rng[0] ? dav_pkg::GAIN_720 : dav_pkg::GAIN_360;
        // signed gain keeps the shift arithmetic for negative sums
        v = (acc[c] * longint'(g)) >>> 1;
        if (v > longint'(dav_pkg::RES_MAX)) v = dav_pkg::RES_MAX;
        if (v < longint'(dav_pkg::RES_MIN)) v = dav_pkg::RES_MIN;
        return a[1] ? v[31:16] : v[15:0];
    endfunction
    // mode 0 zeros, 1 random, 2 full scale (y negative, z zero)
    task automatic step(input int mode);
        for (int c = 0; c < 4; c++) begin
            smp[c] = mode == 0 ? 24'sh0 : mode == 1 ? 24'($random(seed)) :
                c == 1 ? 24'sh800000 : c == 2 ? 24'sh0 : 24'sh7fffff;
            acc[c] += smp[c] + prv[c];
            prv[c] = smp[c];
        end
        strb = 1'b1;
        @(posedge sys_clk_i) #10;
    endtask
    task automatic wait_rdy(input int k);
        for (int i = 0; i < 60 && nrdy == k; i++) @(posedge sys_clk_i) #10;
        if (nrdy != k + 1) begin
            $display("MISMATCH t=%0t exp=%h got=%h", $time, k + 1, nrdy);
            err_total++;
            test_done();
        end
    endtask
    // decimation takes hold only after the update in progress, range already on its result
    task automatic flush;
        int k;
        k = nrdy;
        for (int i = 0; i < 100 && nrdy == k; i++) begin
            step(0);
            strb = 1'b0;
            repeat (2) @(posedge sys_clk_i) #10;
        end
        if (nrdy == k) begin
            $display("MISMATCH t=%0t exp=%h got=%h", $time, k + 1, nrdy);
            err_total++;
            test_done();
        end
        acc = '{default: 0};
    endtask
    task automatic run(input int mode, input int n);
        int k;
        k = nrdy;
        for (int i = 0; i < n; i++) step(mode);
        strb = 1'b0;
        wait_rdy(k);
    endtask
    task automatic rdall;
        logic [6:0] a;
        for (int i = 'h22; i <= 'h36; i++) begin
            a = 7'(i > 'h34 ? 'h26 : i);
            expq.push_back(expw(a));
            host.rd(a, i == 'h36);
        end
        repeat (3) @(posedge sys_clk_i) #10;
    endtask
    initial begin
        int k0;
        #1 rst_i = 1'b1;
        repeat (5) @(posedge sys_clk_i);
        #10 rst_i = 1'b0;
        rdall();
        $display("test reset words done");
        for (int r = 0; r < 4; r++) for (int d = 0; d < 3; d++) begin
            rng = 2'(r);
            dec = 16'(d);
            flush();
            run(1, d + 1);
            rdall();
            $display("test range %0d decimation %0d done", r, d);
        end
        rng = 2'b00;
        dec = 16'd49;
        flush();
        run(2, 50);
        rdall();
        $display("test saturation done");
        // at decimation zero the host sees one ready per sample
        dec = 16'h0000;
        flush();
        k0 = nrdy;
        for (int i = 0; i < 4; i++) begin
            step(0);
            strb = 1'b0;
            @(posedge sys_clk_i) #10;
        end
        repeat (2) @(posedge sys_clk_i) #10;
        n_checks++;
        if (nrdy != k0 + 4) begin
            $display("MISMATCH t=%0t exp=%h got=%h", $time, k0 + 4, nrdy);
            err_total++;
        end
        $display("test ready rate done");
        rst_i = 1'b1;
        repeat (2) @(posedge sys_clk_i) #10;
        rst_i = 1'b0;
        acc = '{default: 0};
        prv = '{default: 0};
        rdall();
        $display("test mid-run reset done");
        test_done();
    end
endmodule
`default_nettype wire

/* File: verification/dav_delta_outputs_chk.sv */
// concurrent checks on the delta output block ports
`default_nettype none
module dav_delta_outputs_chk (
    input  wire logic                          sys_clk_i,
    input  wire logic                          rst_i,
    input  wire logic                          sample_strobe_i,
    input  wire logic                          reg_rd_i,
    input  wire logic [dav_pkg::ADDR_W-1:0]    reg_addr_i,
    input  wire logic [dav_pkg::HALF_W-1:0]    reg_rdata_o,
    input  wire logic                          reg_rvalid_o,
    input  wire logic                          sample_ready_pin_o
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);
    sequence rd_pair_s;
        reg_rd_i ##1 (reg_rd_i && $stable(reg_addr_i));
    endsequence
    sequence no_load_s;
        !sample_ready_pin_o;
    endsequence
    rd_answer_a: assert property (reg_rd_i |=> reg_rvalid_o)
        else $error("read not answered next cycle");
    valid_cause_a: assert property (reg_rvalid_o |-> $past(reg_rd_i))
        else $error("read valid without a read");
    rdata_hold_a: assert property (
        !reg_rd_i |=> $stable(reg_rdata_o))
        else $error("read data moved without a read");
    unmap_zero_a: assert property (
        reg_rd_i && (reg_addr_i < dav_pkg::OFS_X_ANG_LO ||
                     reg_addr_i > dav_pkg::OFS_LAST)
        |=> reg_rdata_o == 16'h0000)
        else $error("unmapped read not zero");
    ready_cause_a: assert property (
        sample_ready_pin_o |-> $past(sample_strobe_i, 2))
        else $error("ready without a strobe two cycles before");
    ready_once_a: assert property (
        sample_ready_pin_o && !$past(sample_strobe_i) |=> !sample_ready_pin_o)
        else $error("ready longer than one cycle");
    // a load between two reads shows as ready at the second read
    upd_hold_a: assert property (
        rd_pair_s ##0 no_load_s |=> $stable(reg_rdata_o))
        else $error("word changed without an update");
    reset_quiet_a: assert property (disable iff (1'b0)
        rst_i |-> !reg_rvalid_o && !sample_ready_pin_o &&
                  reg_rdata_o == 16'h0000)
        else $error("outputs active in reset");
endmodule
bind dav_delta_outputs dav_delta_outputs_chk chk_i (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .sample_strobe_i(sample_strobe_i),
    .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i), .reg_rdata_o(reg_rdata_o),
    .reg_rvalid_o(reg_rvalid_o), .sample_ready_pin_o(sample_ready_pin_o));
`default_nettype wire

/* File: verification/dav_host_model.sv */
// host side model issuing register reads
`default_nettype none
module dav_host_model (
    input  wire logic                          sys_clk_i,
    output logic                               reg_rd_o,
    output logic [dav_pkg::ADDR_W-1:0]         reg_addr_o
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        reg_rd_o = 1'b0;
        reg_addr_o = 7'h00;
    end
    // request held to the sampling edge; address inverted once released
    task automatic rd(input logic [6:0] a, input bit last);
        reg_rd_o = 1'b1;
        reg_addr_o = a;
        @(posedge sys_clk_i) #10;
        if (last) begin
            reg_rd_o = 1'b0;
            reg_addr_o = ~a;
        end
    endtask
endmodule
`default_nettype wire
